/* File: core/sesum_status.sv */
// status event summary: two latched event registers, two enable masks,
// two summary bits of the status byte, error queue push strobe.
// assumes command decode on core_clk issues one-cycle strobes; condition
// inputs come from analog or other clock domains and are synchronised.
//
// How it works
// (R01) event bits latch until explicitly cleared
// (R02) query read or clear-status clears events
// (R03) reset or device clear keeps events
// (R04) read returns weighted sum of bits
// (R05) summary is OR of masked events
// (R06) masks read and write, reads harmless
// (R07) clear-status leaves masks untouched
// (R08) questionable_summary bit0 voltage, bit1 current unregulated
// (R09) questionable_summary bit4 fan, bit9 ovp, bit10 ocp
// (R10) writing zero empties questionable mask
// (R11) status byte bit5 is standard summary
// (R12) std bits 2..5 push error queue
// (R13) bit0 set after marker command completes
// (R14) bit2 on query buffer faults
// (R15) bit3 on self-test or calibration fail
// (R16) bit4 on execution failure
// (R17) bit5 on command syntax error
// (R18) bit7 after power cycle
// (R19) power-on clears std mask if setting
// (R20) host writes mask as weighted sum
// (R21) status byte bit3 is questionable summary
// (R22) unused event bits read zero
`timescale 1ns/1ps
`include "sesum_defines.svh"

module sesum_status (
   input  wire logic        core_clk,        // instrument clock
   input  wire logic        nrst,            // async reset, active low
   // condition levels from the supply, async
   input  wire logic        volt_unreg,      // voltage out of regulation
   input  wire logic        curr_unreg,      // current out of regulation
   input  wire logic        fan_overtemp,    // fan fault
   input  wire logic        ovp_tripped,     // overvoltage trip
   input  wire logic        ocp_tripped,     // overcurrent trip
   // event strobes from command logic, same clock
   input  wire logic        opc_done,        // marker command finished
   input  wire logic        query_fault,     // query buffer fault
   input  wire logic        selftest_fail,   // self-test or cal failure
   input  wire logic        exec_fail,       // execution error
   input  wire logic        syntax_fail,     // syntax error
   input  wire logic        clear_status,    // clear-status command
   input  wire logic        instr_reset,     // instrument reset command
   input  wire logic        device_clear,    // device clear action
   // stored power-on-clear setting, nonvolatile
   input  wire logic        power_on_clear_setting, // 1 clears mask
   input  wire logic [7:0]  std_mask_saved,  // mask kept across power
   // register access
   input  wire logic        questionable_summary_read,       // questionable event query
   input  wire logic        std_read,        // standard event query
   input  wire logic        questionable_mask_write, // questionable_summary mask load
   input  wire logic [15:0] questionable_summary_mask_wdata, // questionable_summary mask value
   input  wire logic        std_mask_write,  // std mask load
   input  wire logic [7:0]  std_mask_wdata,  // std mask value
   output logic [15:0]      questionable_summary_rdata,      // event value at query
   output logic [7:0]       std_rdata,       // event value at query
   output logic [15:0]      questionable_summary_mask,       // questionable_summary enable mask
   output logic [7:0]       std_mask,        // std enable mask
   output logic             questionable_summary,  // status byte bit 3
   output logic             standard_event_summary, // status byte bit 5
   output logic [7:0]       status_summary,  // status byte bits 3,5
   output logic             err_push         // error queue push pulse
);

   // ************************************
   // condition synchronisers
   // ************************************
   logic [4:0] cond_s1_r;
   logic [4:0] cond_s2_r;
   wire  [4:0] cond_raw = {ocp_tripped, ovp_tripped, fan_overtemp,
                           curr_unreg, volt_unreg};

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cond_s1_r <= 5'h00;
         cond_s2_r <= 5'h00;
      end else begin
         cond_s1_r <= cond_raw;
         cond_s2_r <= cond_s1_r;
      end
   end

   // ************************************
   // questionable event register
   // ************************************
   sesum_pkg::sesum_questionable_summary_t questionable_summary_r;
   sesum_pkg::sesum_questionable_summary_t questionable_summary_nxt;
   sesum_pkg::sesum_questionable_summary_t questionable_summary_set;

   always_comb begin
      questionable_summary_set = `SESUM_QUESTIONABLE_SUMMARY_RST;
      questionable_summary_set[`SESUM_QUESTIONABLE_SUMMARY_VOLT_BIT] = cond_s2_r[0]; // [R08]
      questionable_summary_set[`SESUM_QUESTIONABLE_SUMMARY_CURR_BIT] = cond_s2_r[1]; // [R08]
      questionable_summary_set[`SESUM_QUESTIONABLE_SUMMARY_TEMP_BIT] = cond_s2_r[2]; // [R09]
      questionable_summary_set[`SESUM_QUESTIONABLE_SUMMARY_OVP_BIT]  = cond_s2_r[3]; // [R09]
      questionable_summary_set[`SESUM_QUESTIONABLE_SUMMARY_OCP_BIT]  = cond_s2_r[4]; // [R09]
   end

   // a condition present during the clearing cycle survives the clear;
   // reset and device clear deliberately do not touch events
   wire questionable_summary_clr = questionable_summary_read | clear_status;           // [R02] [R03]
   assign questionable_summary_nxt = ((questionable_summary_clr ? `SESUM_QUESTIONABLE_SUMMARY_RST : questionable_summary_r) | questionable_summary_set)
                     & `SESUM_QUESTIONABLE_SUMMARY_USED;                // [R01] [R22]

   // ************************************
   // standard event register
   // ************************************
   sesum_pkg::sesum_std_t std_r;
   sesum_pkg::sesum_std_t std_nxt;
   sesum_pkg::sesum_std_t std_set;
   logic                  pwr_flag_r;

   always_comb begin
      std_set = `SESUM_STD_RST;
      std_set[`SESUM_STD_OPC_BIT] = opc_done;          // [R13]
      std_set[`SESUM_STD_QYE_BIT] = query_fault;       // [R14]
      std_set[`SESUM_STD_DEV_BIT] = selftest_fail;     // [R15]
      std_set[`SESUM_STD_EXE_BIT] = exec_fail;         // [R16]
      std_set[`SESUM_STD_CMD_BIT] = syntax_fail;       // [R17]
      std_set[`SESUM_STD_PWR_BIT] = pwr_flag_r;        // [R18]
   end

   wire std_clr = std_read | clear_status;             // [R02] [R03]
   assign std_nxt = ((std_clr ? `SESUM_STD_RST : std_r) | std_set)
                    & `SESUM_STD_USED;                  // [R01] [R22]

   // ************************************
   // power-up sequence
   // ************************************
   // setting and saved mask are caught after release, never under reset
   sesum_pkg::sesum_pwr_t pwr_r;
   sesum_pkg::sesum_pwr_t pwr_nxt;

   always_comb begin
      case (pwr_r)
         sesum_pkg::SESUM_PWR_BOOT: pwr_nxt = sesum_pkg::SESUM_PWR_LOAD;
         sesum_pkg::SESUM_PWR_LOAD: pwr_nxt = sesum_pkg::SESUM_PWR_RUN;
         sesum_pkg::SESUM_PWR_RUN:  pwr_nxt = sesum_pkg::SESUM_PWR_RUN;
         default:                   pwr_nxt = sesum_pkg::SESUM_PWR_BOOT;
      endcase
   end

   wire pwr_load = (pwr_r == sesum_pkg::SESUM_PWR_LOAD);

   // ************************************
   // enable masks
   // ************************************
   logic [15:0] questionable_summary_mask_r;
   logic [7:0]  std_mask_r;
   wire  [7:0]  std_mask_boot = power_on_clear_setting ?
                                `SESUM_STD_RST : std_mask_saved; // [R19]
   // masks have no clear-status path at all
   wire  [15:0] questionable_summary_mask_nxt = questionable_mask_write ?
                                questionable_summary_mask_wdata : questionable_summary_mask_r; // [R06] [R07] [R10]
   wire  [7:0]  std_mask_nxt  = pwr_load ? std_mask_boot :
                                std_mask_write ? std_mask_wdata :
                                std_mask_r;     // [R06] [R07] [R20]

   // ************************************
   // summaries and read data
   // ************************************
   wire questionable_summary_sum_nxt = |(questionable_summary_nxt & questionable_summary_mask_nxt);      // [R05] [R21]
   wire std_sum_nxt  = |(std_nxt & std_mask_nxt);        // [R05] [R11]
   wire [7:0] stb_nxt = {2'b00, std_sum_nxt, 1'b0, questionable_summary_sum_nxt, 3'b000};
   // value returned is the plain binary word, i.e. the weighted sum
   wire [15:0] questionable_summary_rd_nxt = questionable_summary_read ? questionable_summary_r : questionable_summary_rdata; // [R04]
   wire [7:0]  std_rd_nxt  = std_read ? std_r : std_rdata;    // [R04]
   // every cycle with a new error pushes once, even when its bit is already latched,
   // so the queue sees repeats and not just the first; errors in one cycle share a push
   wire err_push_nxt = |(std_set & `SESUM_STD_ERRS); // [R12]

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         questionable_summary_r                 <= `SESUM_QUESTIONABLE_SUMMARY_RST;
         std_r                  <= `SESUM_STD_RST;
         pwr_flag_r             <= 1'b1;
         pwr_r                  <= sesum_pkg::SESUM_PWR_BOOT;
         questionable_summary_mask_r            <= `SESUM_QUESTIONABLE_SUMMARY_RST;
         std_mask_r             <= `SESUM_STD_RST;
         questionable_summary   <= 1'b0;
         standard_event_summary <= 1'b0;
         status_summary         <= `SESUM_STB_RST;
         questionable_summary_rdata             <= `SESUM_QUESTIONABLE_SUMMARY_RST;
         std_rdata              <= `SESUM_STD_RST;
         err_push               <= 1'b0;
      end else begin
         questionable_summary_r                 <= questionable_summary_nxt;
         std_r                  <= std_nxt;
         pwr_flag_r             <= 1'b0;
         pwr_r                  <= pwr_nxt;
         questionable_summary_mask_r            <= questionable_summary_mask_nxt;
         std_mask_r             <= std_mask_nxt;
         questionable_summary   <= questionable_summary_sum_nxt;
         standard_event_summary <= std_sum_nxt;
         status_summary         <= stb_nxt;
         questionable_summary_rdata             <= questionable_summary_rd_nxt;
         std_rdata              <= std_rd_nxt;
         err_push               <= err_push_nxt;
      end
   end

   assign questionable_summary_mask = questionable_summary_mask_r;
   assign std_mask  = std_mask_r;

   // instrument reset and device clear are accepted and have no effect here
   wire unused_ok = instr_reset | device_clear;

endmodule : sesum_status

/* File: core/sesum_defines.svh */
// status event summary constants: register layouts, bit positions
// assumes inclusion by bare name from the package and the design file
`ifndef SESUM_DEFINES_SVH
`define SESUM_DEFINES_SVH

// ************************************
// questionable event layout
// ************************************
`define SESUM_QUESTIONABLE_SUMMARY_W         16
`define SESUM_QUESTIONABLE_SUMMARY_VOLT_BIT  0
`define SESUM_QUESTIONABLE_SUMMARY_CURR_BIT  1
`define SESUM_QUESTIONABLE_SUMMARY_TEMP_BIT  4
`define SESUM_QUESTIONABLE_SUMMARY_OVP_BIT   9
`define SESUM_QUESTIONABLE_SUMMARY_OCP_BIT   10
`define SESUM_QUESTIONABLE_SUMMARY_USED      16'h0613

// ************************************
// standard event layout
// ************************************
`define SESUM_STD_W          8
`define SESUM_STD_OPC_BIT    0
`define SESUM_STD_QYE_BIT    2
`define SESUM_STD_DEV_BIT    3
`define SESUM_STD_EXE_BIT    4
`define SESUM_STD_CMD_BIT    5
`define SESUM_STD_PWR_BIT    7
`define SESUM_STD_USED       8'hbd
`define SESUM_STD_ERRS       8'h3c

// ************************************
// status byte positions
// ************************************
`define SESUM_STB_QUESTIONABLE_SUMMARY_BIT   3
`define SESUM_STB_ESB_BIT    5

// ************************************
// reset values
// ************************************
`define SESUM_QUESTIONABLE_SUMMARY_RST       16'h0000
`define SESUM_STD_RST        8'h00
`define SESUM_STB_RST        8'h00

`endif

/* File: core/sesum_pkg.sv */
// status event summary types
// assumes the defines header sits beside it
`include "sesum_defines.svh"
package sesum_pkg;
   typedef logic [`SESUM_QUESTIONABLE_SUMMARY_W-1:0] sesum_questionable_summary_t;
   typedef logic [`SESUM_STD_W-1:0]  sesum_std_t;
   typedef enum logic [1:0] {
      SESUM_PWR_BOOT = 2'b00,
      SESUM_PWR_LOAD = 2'b01,
      SESUM_PWR_RUN  = 2'b10
   } sesum_pwr_t;
endpackage : sesum_pkg

/* File: dv/sesum_status_monitor.sv */
// checker for the status event summary block
// assumes binding onto sesum_status, ports matched by name
`timescale 1ns/1ps
`include "sesum_defines.svh"

module sesum_status_mon (
   input logic        core_clk,
   input logic        nrst,
   input logic        opc_done,
   input logic        query_fault,
   input logic        selftest_fail,
   input logic        exec_fail,
   input logic        syntax_fail,
   input logic        clear_status,
   input logic        std_read,
   input logic        std_mask_write,
   input logic        questionable_mask_write,
   input logic [15:0] questionable_summary_mask_wdata,
   input logic [15:0] questionable_summary_mask,
   input logic [7:0]  std_mask,
   input logic [15:0] questionable_summary_rdata,
   input logic [7:0]  std_rdata,
   input logic        questionable_summary,
   input logic        standard_event_summary,
   input logic [7:0]  status_summary,
   input logic        err_push
);
   // ************************************
   // assertions
   // ************************************
   wire errs = query_fault | selftest_fail | exec_fail | syntax_fail;
   wire any_std = errs | opc_done;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   stb_bits_a : assert property (status_summary ==
      {2'b00, standard_event_summary, 1'b0, questionable_summary, 3'b000})
      else $error("status byte layout");
   qmask_load_a : assert property (questionable_mask_write |=>
      questionable_summary_mask == $past(questionable_summary_mask_wdata)) else $error("questionable_summary mask load");
   qmask_hold_a : assert property (!questionable_mask_write |=>
      $stable(questionable_summary_mask)) else $error("questionable_summary mask drift");
   syn_flag_a : assert property (syntax_fail ##1 std_read |=>
      std_rdata[5]) else $error("syntax flag lost");
   exe_flag_a : assert property (exec_fail ##1 std_read |=>
      std_rdata[4]) else $error("exec flag lost");
   rd_clear_a : assert property (std_read && !any_std ##1
      !std_read && !any_std ##1 std_read && !any_std |=> std_rdata == 8'h00)
      else $error("query did not clear");
   push_cause_a : assert property (err_push |-> $past(errs))
      else $error("push without error");
   push_each_a : assert property (errs |=> err_push)
      else $error("error not pushed");
   esb_set_a : assert property (syntax_fail ##1 (std_mask[5]
      && !std_read && !clear_status && !std_mask_write) |=>
      standard_event_summary) else $error("summary missing");
   unused_zero_a : assert property (
      (std_rdata & ~`SESUM_STD_USED) == 8'h00 &&
      (questionable_summary_rdata & ~`SESUM_QUESTIONABLE_SUMMARY_USED) == 16'h0000)
      else $error("unused bit set");

   cover property (syntax_fail ##1 std_read);
   cover property (err_push);
   cover property (questionable_summary);
endmodule : sesum_status_mon

/* File: dv/sesum_status_tb.sv */
// self-checking bench for the status event summary block
// assumes the checker file is compiled alongside
`timescale 1ns/1ps

module sesum_status_tb;
   logic        core_clk = 1'b0;
   logic        nrst     = 1'b0;
   logic [4:0]  cond     = 5'h00; // volt, curr, temp, ovp, ocp
   logic [4:0]  stb      = 5'h00; // opc, query, device, exec, syntax
   logic        clr = 1'b0, irst = 1'b0, dclr = 1'b0;
   logic        pocs     = 1'b0; // stored power-on-clear setting
   logic        qrd = 1'b0, srd = 1'b0, qmw = 1'b0, smw = 1'b0;
   logic [15:0] qwd = 16'h0000;
   logic [7:0]  swd = 8'h00;
   logic [15:0] questionable_summary_rdata, questionable_summary_mask;
   logic [7:0]  std_rdata, std_mask, status_summary;
   logic        questionable_summary_sum, std_sum, err_push;
   int          err_count = 0;
   int          total_checks = 0;

   sesum_status dut_u (.core_clk(core_clk), .nrst(nrst),
      .volt_unreg(cond[0]), .curr_unreg(cond[1]), .fan_overtemp(cond[2]),
      .ovp_tripped(cond[3]), .ocp_tripped(cond[4]), .opc_done(stb[0]),
      .query_fault(stb[1]), .selftest_fail(stb[2]), .exec_fail(stb[3]),
      .syntax_fail(stb[4]), .clear_status(clr), .instr_reset(irst),
      .device_clear(dclr), .power_on_clear_setting(pocs),
      .std_mask_saved(8'h24), .questionable_summary_read(qrd), .std_read(srd),
      .questionable_mask_write(qmw), .questionable_summary_mask_wdata(qwd),
      .std_mask_write(smw), .std_mask_wdata(swd), .questionable_summary_rdata(questionable_summary_rdata),
      .std_rdata(std_rdata), .questionable_summary_mask(questionable_summary_mask), .std_mask(std_mask),
      .questionable_summary(questionable_summary_sum), .standard_event_summary(std_sum),
      .status_summary(status_summary), .err_push(err_push));

   // ************************************
   // access tasks
   // ************************************
   always #10 core_clk = ~core_clk;

   task step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step

   task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // query one event register; a gap cycle follows so strobes never merge
   task rd(input bit q, input logic [15:0] exp);
      qrd = q;
      srd = !q;
      step(1);
      qrd = 1'b0;
      srd = 1'b0;
      chk("event", exp, q ? questionable_summary_rdata : {8'h00, std_rdata});
      step(1);
   endtask : rd

   task wr(input bit q, input logic [15:0] d);
      qmw = q;
      smw = !q;
      qwd = d;
      swd = d[7:0];
      step(1);
      qmw = 1'b0;
      smw = 1'b0;
      step(1);
   endtask : wr

   task results;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results

   initial begin
      #200us;
      err_count++;
      results();
   end

   // ************************************
   // scenarios
   // ************************************
   initial begin
      step(12);
      nrst = 1'b1;
      step(3);
      chk("std_mask", 16'h0024, {8'h00, std_mask});
      rd(0, 16'h0080);
      rd(0, 16'h0000);
      stb = 5'h10;
      step(1);
      stb = 5'h00;
      chk("err_push", 16'h0001, {15'h0, err_push});
      step(1);
      chk("status", 16'h0020, {8'h00, status_summary});
      chk("std_sum", 16'h0001, {15'h0, std_sum});
      // same error again while its bit is latched
      stb = 5'h10;
      step(1);
      stb = 5'h00;
      chk("err_push", 16'h0001, {15'h0, err_push});
      irst = 1'b1;
      dclr = 1'b1;
      step(1);
      irst = 1'b0;
      dclr = 1'b0;
      step(2);
      rd(0, 16'h0020);
      stb = 5'h01;
      step(1);
      stb = 5'h00;
      chk("err_push", 16'h0000, {15'h0, err_push});
      step(1);
      chk("status", 16'h0000, {8'h00, status_summary});
      rd(0, 16'h0001);
      stb = 5'h1f;
      step(1);
      stb = 5'h00;
      rd(0, 16'h003d);
      stb = 5'h0a;
      step(1);
      stb = 5'h00;
      rd(0, 16'h0014);
      wr(1, 16'h0010);
      chk("questionable_summary_mask", 16'h0010, questionable_summary_mask);
      cond = 5'h1f;
      step(3);
      cond = 5'h00;
      step(3);
      chk("status", 16'h0008, {8'h00, status_summary});
      wr(1, 16'h0000);
      step(1);
      chk("questionable_summary_sum", 16'h0000, {15'h0, questionable_summary_sum});
      rd(1, 16'h0613);
      // split patterns so that swapped condition bits show up
      cond = 5'h15;
      step(3);
      cond = 5'h00;
      step(3);
      rd(1, 16'h0411);
      cond = 5'h0a;
      step(3);
      cond = 5'h00;
      step(3);
      rd(1, 16'h0202);
      cond = 5'h01;
      step(3);
      cond = 5'h00;
      step(2);
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      step(1);
      rd(1, 16'h0000);
      chk("std_mask", 16'h0024, {8'h00, std_mask});
      // second power-up, setting now asks for a cleared mask
      pocs = 1'b1;
      nrst = 1'b0;
      step(2);
      nrst = 1'b1;
      step(3);
      chk("std_mask", 16'h0000, {8'h00, std_mask});
      rd(0, 16'h0080);
      wr(0, 16'h003c);
      chk("std_mask", 16'h003c, {8'h00, std_mask});
      wr(0, 16'h0000);
      chk("std_mask", 16'h0000, {8'h00, std_mask});
      results();
   end
endmodule : sesum_status_tb

bind sesum_status sesum_status_mon mon_u (.*);
